/* hdl/cib_card_info_regs.sv */
// card information registers answered over the card command decoder
// Notes on behaviour
// R1 - busy bit 31 low during power-up routine, high once it completes
// R2 - access-mode field 30:29 reads 10b, sector addressing
// R3 - capacity over 2 GB: every data address counts 512-byte sectors
// R4 - voltage bits 23:15 ones, 14:8 zeros, 7 one, rest zero
// R5 - registers reached only through their own bus commands
// R6 - 128-bit identification word returned during identification phase
// R7 - identification fields: maker, package, application, name, revision, serial, date, checksum, one
// R8 - specific data reports structure 3h and version 4h
// R9 - block lengths 9h; partial and misalignment flags all zero
// R10 - async access time 4Fh; clocked access time in 100-cycle units
// R11 - max clock code 32h, command class mask 8F5h
// R12 - erase group 1Fh/1Fh, protect group 0Fh enabled, size FFFh mult 7h
// R13 - bits 15:1 programmable; copy and permanent one-time; temporary clearable
module cib_card_info_regs
  import cib_pkg::*;
#(
  parameter int          POWERUP_LEN  = POWERUP_CYCLES,
  parameter logic [7:0]  MAKER_CODE   = 8'h5a,        // arbitrary value
  parameter logic [1:0]  PACKAGE_TYPE = 2'h2,         // arbitrary value
  parameter logic [7:0]  APP_CODE     = 8'h3c,        // arbitrary value
  parameter logic [47:0] PRODUCT_NAME = 48'h414243444546, // arbitrary value
  parameter logic [7:0]  PRODUCT_REV  = 8'h10,        // arbitrary value
  parameter logic [31:0] SERIAL_NUM   = 32'h12345678, // arbitrary value
  parameter logic [7:0]  MFG_DATE     = 8'h11         // arbitrary value
) (
  // clock, reset, enable
  input  wire logic      clk,
  input  wire logic      rst_b,
  input  wire logic      clk_en,
  // command decoder side
  input  wire cib_req_t  req,
  output cib_resp_t      resp,
  // status
  output logic           powered_up,
  output logic           sector_addressing
);

  cib_pwr_t     pwr_reg;
  logic [31:0]  pwr_cnt_reg;
  logic [14:0]  csd_wr_reg;
  cib_resp_t    resp_reg;
  logic         ready_reg;
  logic         sector_reg;
  logic [31:0]  ocr_word;
  logic [127:0] cid_word;
  logic [127:0] csd_word;
  logic [119:0] cid_body;

  // R1 power-up routine
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pwr_reg     <= CIB_PWR_BUSY;
      pwr_cnt_reg <= 32'h0;
    end else if (clk_en) begin
      case (pwr_reg)
        CIB_PWR_BUSY: begin
          if (pwr_cnt_reg == 32'(POWERUP_LEN - 1)) begin
            pwr_reg <= CIB_PWR_READY;
          end else begin
            pwr_cnt_reg <= pwr_cnt_reg + 32'h1;
          end
        end
        default: pwr_reg <= CIB_PWR_READY;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ready_reg  <= 1'b0;
      sector_reg <= 1'b0;
    end else if (clk_en) begin
      ready_reg  <= (pwr_reg == CIB_PWR_READY);
      // R3 sector addressing
      sector_reg <= 1'b1;
    end
  end

  always_comb begin
    ocr_word = 32'h0;
    // R1 busy flag
    ocr_word[OCR_BUSY_POS] = (pwr_reg == CIB_PWR_READY);
    // R2 access mode
    ocr_word[OCR_MODE_LSB +: 2] = OCR_MODE_SECTOR;
    // R4 voltage window
    ocr_word[OCR_HIGHV_LSB +: 9] = OCR_HIGHV_VAL;
    ocr_word[OCR_LOWV_POS] = 1'b1;
  end

  // R7 identification layout, checksum over the upper 120 bits
  assign cid_body = {MAKER_CODE, 6'h00, PACKAGE_TYPE, APP_CODE, PRODUCT_NAME,
                     PRODUCT_REV, SERIAL_NUM, MFG_DATE};
  assign cid_word = {cid_body, cib_crc7(cid_body), 1'b1};

  // R8 R9 R10 R11 R12 fixed fields, R13 writable slice
  always_comb begin
    csd_word = cib_spec_fixed();
    csd_word[CSD_WR_LSB +: 15] = csd_wr_reg;
  end

  // R13 programming; once-only bits can only be set, never cleared
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      csd_wr_reg <= CSD_WR_RESET;
    end else if (clk_en && req.valid && req.prog && req.sel == CIB_SEL_SPEC && ready_reg) begin
      csd_wr_reg <= req.data[CSD_WR_LSB +: 15];
      csd_wr_reg[CSD_COPY_BIT] <= req.data[CSD_COPY_BIT + CSD_WR_LSB] | csd_wr_reg[CSD_COPY_BIT];
      csd_wr_reg[CSD_PERM_BIT] <= req.data[CSD_PERM_BIT + CSD_WR_LSB] | csd_wr_reg[CSD_PERM_BIT];
    end
  end

  // R5 R6 one answer per command; program of a read-only block is refused
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      resp_reg <= '0;
    end else if (clk_en) begin
      resp_reg.valid   <= req.valid;
      resp_reg.refused <= req.valid && req.prog && (req.sel != CIB_SEL_SPEC || !ready_reg);
      if (req.valid) begin
        case (req.sel)
          CIB_SEL_OPCOND: resp_reg.data <= {96'h0, ocr_word};
          CIB_SEL_IDENT:  resp_reg.data <= cid_word;
          default:        resp_reg.data <= csd_word;
        endcase
      end
    end
  end

  assign resp              = resp_reg;
  assign powered_up        = ready_reg;
  assign sector_addressing = sector_reg;

  // helper: which register the last answer came from
  cib_sel_t last_sel_reg;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      last_sel_reg <= CIB_SEL_OPCOND;
    end else if (clk_en && req.valid) begin
      last_sel_reg <= req.sel;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  property p_busy_low;
    resp.valid && last_sel_reg == CIB_SEL_OPCOND && $past(pwr_reg) == CIB_PWR_BUSY |-> !resp.data[31];
  endproperty
  a_busy_low: assert property (p_busy_low) else $error("busy bit high during power-up"); // R1
  property p_ready_follows;
    $rose(pwr_reg == CIB_PWR_READY) && clk_en |=> powered_up;
  endproperty
  a_ready_follows: assert property (p_ready_follows) else $error("ready flag late"); // R1
  property p_mode;
    resp.valid && last_sel_reg == CIB_SEL_OPCOND |-> resp.data[30:29] == 2'h2;
  endproperty
  a_mode: assert property (p_mode) else $error("access mode not sector"); // R2
  // first edge after release has not set the flag yet
  property p_sector;
    $past(clk_en) && $past(rst_b) |-> sector_addressing;
  endproperty
  a_sector: assert property (p_sector) else $error("sector addressing flag low"); // R3
  property p_volt;
    resp.valid && last_sel_reg == CIB_SEL_OPCOND |-> resp.data[30:0] == 31'h40ff8080;
  endproperty
  a_volt: assert property (p_volt) else $error("voltage window wrong"); // R4
  property p_answer;
    req.valid && clk_en |=> resp.valid;
  endproperty
  a_answer: assert property (p_answer) else $error("command not answered"); // R6
  property p_cid;
    resp.valid && last_sel_reg == CIB_SEL_IDENT |-> resp.data[0] && resp.data[119:114] == 6'h0
      && resp.data[7:1] == cib_crc7(resp.data[127:8]);
  endproperty
  a_cid: assert property (p_cid) else $error("identification word malformed"); // R7
  property p_csd_head;
    resp.valid && last_sel_reg == CIB_SEL_SPEC |-> resp.data[127:122] == 6'h34
      && resp.data[119:84] == 36'h4f01328f5;
  endproperty
  a_csd_head: assert property (p_csd_head) else $error("specific data header wrong"); // R8
  property p_csd_blk;
    resp.valid && last_sel_reg == CIB_SEL_SPEC |-> resp.data[83:76] == 8'h90 && resp.data[25:21] == 5'h12;
  endproperty
  a_csd_blk: assert property (p_csd_blk) else $error("block length fields wrong"); // R9
  property p_csd_groups;
    resp.valid && last_sel_reg == CIB_SEL_SPEC |-> resp.data[73:62] == 12'hfff
      && resp.data[49:31] == 19'h7ffdf;
  endproperty
  a_csd_groups: assert property (p_csd_groups) else $error("group fields wrong"); // R12
  property p_perm_sticky;
    csd_wr_reg[CSD_PERM_BIT] && clk_en |=> csd_wr_reg[CSD_PERM_BIT];
  endproperty
  a_perm_sticky: assert property (p_perm_sticky) else $error("permanent protection cleared"); // R13
  property p_copy_sticky;
    csd_wr_reg[CSD_COPY_BIT] |=> csd_wr_reg[CSD_COPY_BIT];
  endproperty
  a_copy_sticky: assert property (p_copy_sticky) else $error("copy flag cleared"); // R13
  // a refused program must leave the stored slice alone
  property p_refused_keeps;
    resp.valid && resp.refused |-> $stable(csd_wr_reg);
  endproperty
  a_refused_keeps: assert property (p_refused_keeps) else $error("refused program changed store"); // R13
  property p_early_refused;
    req.valid && req.prog && !ready_reg && clk_en |=> resp.refused;
  endproperty
  a_early_refused: assert property (p_early_refused) else $error("program during power-up accepted"); // R13
  property p_no_request;
    !req.valid && clk_en |=> !resp.valid;
  endproperty
  a_no_request: assert property (p_no_request) else $error("answer without request"); // R5
  property p_tmp_clear;
    req.valid && req.prog && req.sel == CIB_SEL_SPEC && ready_reg && clk_en
      && !req.data[CSD_TMP_BIT + CSD_WR_LSB] |=> !csd_wr_reg[CSD_TMP_BIT];
  endproperty
  a_tmp_clear: assert property (p_tmp_clear) else $error("temporary protection not cleared"); // R13

  c_ready: cover property ($rose(powered_up));
  c_prog: cover property (req.valid && req.prog && req.sel == CIB_SEL_SPEC && ready_reg);
  c_tmp_clear: cover property (csd_wr_reg[CSD_TMP_BIT] ##1 !csd_wr_reg[CSD_TMP_BIT]);
  c_refused: cover property (resp.valid && resp.refused);
  c_busy_answer: cover property (resp.valid && last_sel_reg == CIB_SEL_OPCOND && !resp.data[OCR_BUSY_POS]);

endmodule : cib_card_info_regs

/* include/cib_pkg.sv */
// shared constants, types and helpers for the card information register bank
package cib_pkg;

  // operating conditions word layout and values
  localparam int          OCR_BUSY_POS     = 31;
  localparam int          OCR_MODE_LSB     = 29;
  localparam logic [1:0]  OCR_MODE_SECTOR  = 2'h2;
  localparam int          OCR_HIGHV_LSB    = 15;
  localparam logic [8:0]  OCR_HIGHV_VAL    = 9'h1ff;
  localparam int          OCR_LOWV_POS     = 7;

  // identification block layout
  localparam int          CID_MAKER_LSB    = 120;
  localparam int          CID_PKG_LSB      = 112;
  localparam int          CID_APP_LSB      = 104;
  localparam int          CID_NAME_LSB     = 56;
  localparam int          CID_REV_LSB      = 48;
  localparam int          CID_SERIAL_LSB   = 16;
  localparam int          CID_DATE_LSB     = 8;
  localparam int          CID_CRC_LSB      = 1;

  // specific data block fixed fields
  localparam int          CSD_STRUCT_LSB   = 126;
  localparam logic [1:0]  CSD_STRUCT_VAL   = 2'h3;
  localparam int          CSD_SPEC_LSB     = 122;
  localparam logic [3:0]  CSD_SPEC_VAL     = 4'h4;
  localparam int          CSD_ASYNC_LSB    = 112;
  localparam logic [7:0]  CSD_ASYNC_VAL    = 8'h4f;
  localparam int          CSD_CLKD_LSB     = 104;
  localparam logic [7:0]  CSD_CLKD_VAL     = 8'h01;
  localparam int          CSD_SPEED_LSB    = 96;
  localparam logic [7:0]  CSD_SPEED_VAL    = 8'h32;
  localparam int          CSD_CCC_LSB      = 84;
  localparam logic [11:0] CSD_CCC_VAL      = 12'h8f5;
  localparam int          CSD_RDLEN_LSB    = 80;
  localparam int          CSD_WRLEN_LSB    = 22;
  localparam logic [3:0]  CSD_BLKLEN_VAL   = 4'h9;
  localparam int          CSD_SIZE_LSB     = 62;
  localparam logic [11:0] CSD_SIZE_VAL     = 12'hfff;
  localparam int          CSD_CURR_LSB     = 50;
  localparam logic [11:0] CSD_CURR_VAL     = 12'hfff;
  localparam int          CSD_SMULT_LSB    = 47;
  localparam logic [2:0]  CSD_SMULT_VAL    = 3'h7;
  localparam int          CSD_ERGRP_LSB    = 37;
  localparam logic [9:0]  CSD_ERGRP_VAL    = 10'h3ff;
  localparam int          CSD_WPGRP_LSB    = 32;
  localparam logic [4:0]  CSD_WPGRP_VAL    = 5'h0f;
  localparam int          CSD_WPEN_POS     = 31;
  localparam int          CSD_R2W_LSB      = 26;
  localparam logic [2:0]  CSD_R2W_VAL      = 3'h2;

  // specific data block writable slice [15:1]
  localparam int          CSD_WR_LSB       = 1;
  localparam int          CSD_FGRP_BIT     = 14;
  localparam int          CSD_COPY_BIT     = 13;
  localparam int          CSD_PERM_BIT     = 12;
  localparam int          CSD_TMP_BIT      = 11;
  localparam logic [14:0] CSD_WR_RESET     = 15'h002e;

  // power-up routine length
  localparam int          POWERUP_NS       = 1000000;
  localparam int          CLK_PERIOD_NS    = 5;
  localparam int          POWERUP_CYCLES   = (POWERUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    CIB_SEL_OPCOND,
    CIB_SEL_IDENT,
    CIB_SEL_SPEC
  } cib_sel_t;

  typedef enum logic {
    CIB_PWR_BUSY,
    CIB_PWR_READY
  } cib_pwr_t;

  typedef struct packed {
    logic         valid;
    cib_sel_t     sel;
    logic         prog;
    logic [127:0] data;
  } cib_req_t;

  typedef struct packed {
    logic         valid;
    logic         refused;
    logic [127:0] data;
  } cib_resp_t;

  // seven-bit checksum, polynomial x^7 + x^3 + 1, msb first
  function automatic logic [6:0] cib_crc7(input logic [119:0] d);
    logic [6:0] c;
    logic       fb;
    c = 7'h00;
    for (int i = 119; i >= 0; i--) begin
      fb = d[i] ^ c[6];
      c  = {c[5:0], 1'b0};
      if (fb) begin
        c = c ^ 7'h09;
      end
    end
    return c;
  endfunction : cib_crc7

  function automatic logic [127:0] cib_spec_fixed();
    logic [127:0] w;
    w = '0;
    w[CSD_STRUCT_LSB +: 2] = CSD_STRUCT_VAL;
    w[CSD_SPEC_LSB +: 4]   = CSD_SPEC_VAL;
    w[CSD_ASYNC_LSB +: 8]  = CSD_ASYNC_VAL;
    w[CSD_CLKD_LSB +: 8]   = CSD_CLKD_VAL;
    w[CSD_SPEED_LSB +: 8]  = CSD_SPEED_VAL;
    w[CSD_CCC_LSB +: 12]   = CSD_CCC_VAL;
    w[CSD_RDLEN_LSB +: 4]  = CSD_BLKLEN_VAL;
    w[CSD_SIZE_LSB +: 12]  = CSD_SIZE_VAL;
    w[CSD_CURR_LSB +: 12]  = CSD_CURR_VAL;
    w[CSD_SMULT_LSB +: 3]  = CSD_SMULT_VAL;
    w[CSD_ERGRP_LSB +: 10] = CSD_ERGRP_VAL;
    w[CSD_WPGRP_LSB +: 5]  = CSD_WPGRP_VAL;
    w[CSD_WPEN_POS]        = 1'b1;
    w[CSD_R2W_LSB +: 3]    = CSD_R2W_VAL;
    w[CSD_WRLEN_LSB +: 4]  = CSD_BLKLEN_VAL;
    w[0]                   = 1'b1;
    return w;
  endfunction : cib_spec_fixed

endpackage : cib_pkg

/* dv/cib_host_model.sv */
// host-side command model for the card information register bank
module cib_host_model
  import cib_pkg::*;
(
  // clock
  input  wire logic      clk,
  // command port
  output cib_req_t       req,
  input  wire cib_resp_t resp
);
  timeunit 1ns;
  timeprecision 1ps;

  initial req = '0;

  task automatic xfer(input cib_sel_t sel, input logic prog, input logic [127:0] wd,
                      output logic [127:0] rd, output logic refused, output logic ok);
    @(negedge clk);
    req <= {1'b1, sel, prog, wd};
    // answer stands one cycle only: take it before letting go
    @(negedge clk);
    ok      = resp.valid;
    refused = resp.refused;
    rd      = resp.data;
    // released data flips so a stale value never looks valid
    req <= {1'b0, sel, 1'b0, ~wd};
  endtask : xfer
endmodule : cib_host_model

/* dv/tb.sv */
// self-checking bench for the card information register bank
module tb
  import cib_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int           PU_LEN   = 8;
  // identity values are arbitrary
  localparam logic [119:0] ID_HI    = {8'h5a, 6'h00, 2'h2, 8'h3c, 48'h414243444546, 8'h10, 32'h12345678, 8'h11};
  localparam logic [127:0] SPEC_RST = 128'hd04f0132_8f5903ff_ffffffef_8a40005d;
  localparam logic [31:0]  OCR_BASE = 32'h40ff8080;

  logic         clk    = 1'b0;
  logic         rst_b  = 1'b0;
  logic         clk_en = 1'b1;
  cib_req_t     req;
  cib_resp_t    resp;
  logic         powered_up;
  logic         sector_addressing;
  int           err_count = 0;
  int           n_checks  = 0;
  logic [127:0] rd;
  logic         rf;
  logic         ok;

  always #2.5 clk = ~clk;

  cib_card_info_regs #(
    .POWERUP_LEN  (PU_LEN),
    .MAKER_CODE   (ID_HI[119:112]),
    .PACKAGE_TYPE (ID_HI[105:104]),
    .APP_CODE     (ID_HI[103:96]),
    .PRODUCT_NAME (ID_HI[95:48]),
    .PRODUCT_REV  (ID_HI[47:40]),
    .SERIAL_NUM   (ID_HI[39:8]),
    .MFG_DATE     (ID_HI[7:0])
  ) dut (
    .clk               (clk),
    .rst_b             (rst_b),
    .clk_en            (clk_en),
    .req               (req),
    .resp              (resp),
    .powered_up        (powered_up),
    .sector_addressing (sector_addressing)
  );

  cib_host_model host (
    .clk  (clk),
    .req  (req),
    .resp (resp)
  );

  function automatic logic [6:0] crc7(input logic [119:0] d);
    logic [6:0] c;
    c = 7'h00;
    for (int i = 119; i >= 0; i--) begin
      c = {c[5:0], 1'b0} ^ ((d[i] ^ c[6]) ? 7'h09 : 7'h00);
    end
    return c;
  endfunction : crc7

  task automatic chk_word(input string what, input logic [127:0] exp, input logic [127:0] got);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_word

  task automatic chk_bit(input string what, input logic exp, input logic got);
    chk_word(what, {127'h0, exp}, {127'h0, got});
  endtask : chk_bit

  task automatic rq(input cib_sel_t s, input logic p, input logic [127:0] w);
    host.xfer(s, p, w, rd, rf, ok);
    chk_bit("answer valid", 1'b1, ok);
    @(negedge clk);
    chk_bit("answer dropped", 1'b0, resp.valid);
  endtask : rq

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_sim

  initial begin
    #20000;
    err_count++;
    $display("BAD watchdog expected finish seen timeout");
    end_sim();
  end

  initial begin
    repeat (16) @(negedge clk);
    chk_bit("powered_up in reset", 1'b0, powered_up);
    rst_b  <= 1'b1;
    // frozen clock enable must also hold the power-up count
    clk_en <= 1'b0;
    repeat (3 * PU_LEN) @(negedge clk);
    chk_bit("powered_up frozen", 1'b0, powered_up);
    clk_en <= 1'b1;
    rq(CIB_SEL_OPCOND, 1'b0, '0);
    chk_word("opcond busy", {96'h0, OCR_BASE}, rd);
    chk_bit("sector addressing", 1'b1, sector_addressing);
    rq(CIB_SEL_SPEC, 1'b1, '1);
    chk_bit("early program refused", 1'b1, rf);
    rq(CIB_SEL_SPEC, 1'b0, '0);
    chk_word("spec reset value", SPEC_RST, rd);
    $display("test boot done");

    for (int k = 0; k < 4 * PU_LEN && powered_up !== 1'b1; k++) @(negedge clk);
    chk_bit("powered up", 1'b1, powered_up);
    rq(CIB_SEL_OPCOND, 1'b0, '0);
    chk_word("opcond ready", {96'h0, OCR_BASE | 32'h80000000}, rd);
    rq(CIB_SEL_IDENT, 1'b0, '1);
    chk_word("identification", {ID_HI, crc7(ID_HI), 1'b1}, rd);
    $display("test identify done");

    rq(CIB_SEL_SPEC, 1'b1, {{112{1'b1}}, 16'hf0aa});
    chk_bit("program accepted", 1'b0, rf);
    chk_word("answer before program", SPEC_RST, rd);
    rq(CIB_SEL_SPEC, 1'b0, '0);
    chk_word("programmed", {SPEC_RST[127:16], 16'hf0ab}, rd);
    rq(CIB_SEL_SPEC, 1'b1, '0);
    chk_bit("clearing program accepted", 1'b0, rf);
    rq(CIB_SEL_SPEC, 1'b0, '0);
    chk_word("one-time bits kept", {SPEC_RST[127:16], 16'h6001}, rd);
    for (int s = 0; s < 2; s++) begin
      rq(cib_sel_t'(s[1:0]), 1'b1, '0);
      chk_bit("program off spec refused", 1'b1, rf);
    end
    rq(CIB_SEL_IDENT, 1'b0, '0);
    chk_word("identification kept", {ID_HI, crc7(ID_HI), 1'b1}, rd);
    $display("test program done");

    rst_b <= 1'b0;
    @(negedge clk);
    chk_bit("powered_up after reset", 1'b0, powered_up);
    rst_b <= 1'b1;
    rq(CIB_SEL_OPCOND, 1'b0, '0);
    chk_word("opcond busy again", {96'h0, OCR_BASE}, rd);
    $display("test reset done");
    end_sim();
  end
endmodule : tb
